// *** dv/mbsfh_checker.sv ***
// checker for the link that joins the master and device ends
// assumes it sits beside the interface instance, on the core clock
`include "mbsfh_map.svh"

module mbsfh_checker
  import mbsfh_pkg::*;
#(
  parameter longint unsigned IDLE_CYCLES = 200
) (
  // clock and reset
  input wire logic       clock,
  input wire logic       rst_b,
  // request stream
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire logic [7:0] req_data,
  input wire logic       req_last,
  input wire logic [1:0] req_chan,
  // response stream
  input wire logic       rsp_valid,
  input wire logic       rsp_ready,
  input wire logic [7:0] rsp_data,
  input wire logic       rsp_last,
  // tcp state
  input wire logic       tcp_open,
  input wire logic       tcp_close
);
  // ********************
  // byte positions
  // ********************
  logic [5:0]      qn;
  logic [5:0]      pn;
  logic            tq;
  logic [3:0][7:0] ids;
  logic [31:0]     on_n;
  wire logic       qt = req_valid & req_ready;
  wire logic       pt = rsp_valid & rsp_ready;

  // one command at a time, so the framing of the request also names the reply
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      qn <= '0;
      pn <= '0;
      tq <= 1'b0;
      ids <= '0;
      on_n <= '0;
    end else begin
      on_n <= tcp_open ? on_n + 32'h0000_0001 : 32'h0000_0000;
      if (qt) begin
        qn <= req_last ? 6'h00 : qn + 6'h01;
        if (qn == 6'h00) begin
          tq <= (req_chan == `MB_CH_TCP);
        end
        if (qn < 6'h04) begin
          ids[qn[1:0]] <= req_data;
        end
      end
      if (pt) begin
        pn <= rsp_last ? 6'h00 : pn + 6'h01;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // ********************
  // properties
  // ********************
  a_close_pulse: assert property (tcp_close |=> !tcp_close)
    else $error("close held beyond one cycle");
  a_close_early: assert property (tcp_close |-> on_n >= IDLE_CYCLES - 1)
    else $error("close before the idle time");
  a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
    else $error("reply byte changed while stalled");
  a_req_hold: assert property (req_valid && !req_ready |=> req_valid && $stable(req_data))
    else $error("request byte changed while stalled");
  a_rtu_req_len: assert property (qt && req_last && !tq |-> qn == 6'h07)
    else $error("serial request not eight bytes");
  a_tcp_req_len: assert property (qt && req_last && tq |-> qn == 6'h0b)
    else $error("tcp request not twelve bytes");
  a_rtu_rsp_len: assert property (pt && rsp_last && !tq |-> pn inside {[6:30]})
    else $error("serial reply length out of range");
  a_tcp_rsp_len: assert property (pt && rsp_last && tq |-> pn inside {[10:34]})
    else $error("tcp reply length out of range");
  a_tcp_len_field: assert property (pt && tq && pn == 6'h05 |-> rsp_data <= 8'h1d)
    else $error("tcp length field above limit");
  a_tcp_ids: assert property (pt && tq && pn < 6'h04 |-> rsp_data == ids[pn[1:0]])
    else $error("tcp identifiers not repeated");
endmodule

// *** dv/testbench.sv ***
// self-checking bench: master and device ends joined by the link
// assumes the design files and mbsfh_map.svh are compiled before it
module testbench
  import mbsfh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int IDLE = 200;

  logic        clock, rst_b, cmd_valid, reg_ack, reg_bad_addr, reg_bad_value, bad_a, bad_v;
  logic [1:0]  cmd_chan;
  logic [7:0]  cmd_unit, cmd_fc;
  logic [15:0] cmd_tid, cmd_addr, cmd_value, reg_rdata, wd;
  logic [3:0]  rate_set;
  logic [2:0]  fmt_set;
  wire logic   cmd_ready, res_valid, res_refused, res_timeout, res_exception, res_crc_ok;
  wire logic   reg_req, reg_write;
  wire logic [7:0]  res_fc, res_count;
  wire logic [15:0] res_word, reg_addr, reg_wdata;
  wire logic [5:0]  res_len;
  wire logic [3:0]  uart_rate;
  wire logic [2:0]  uart_format;
  int          n_fail, comparisons;

  mbsfh_link_if mbsfh_link_if_inst ();
  mbsfh_master #(.RSP_WAIT(100)) mbsfh_master_inst (
    .clock(clock), .rst_b(rst_b), .link(mbsfh_link_if_inst.master),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_chan(cmd_chan), .cmd_unit(cmd_unit),
    .cmd_fc(cmd_fc), .cmd_tid(cmd_tid), .cmd_addr(cmd_addr), .cmd_value(cmd_value),
    .res_valid(res_valid), .res_refused(res_refused), .res_timeout(res_timeout),
    .res_exception(res_exception), .res_crc_ok(res_crc_ok), .res_fc(res_fc),
    .res_count(res_count), .res_word(res_word), .res_len(res_len));
  mbsfh_device #(.IDLE_CYCLES(IDLE)) mbsfh_device_inst (
    .clock(clock), .rst_b(rst_b), .link(mbsfh_link_if_inst.device),
    .serial_line_rate_setting(rate_set), .serial_char_format_setting(fmt_set),
    .station_address(8'h11), .uart_rate(uart_rate), .uart_format(uart_format),
    .reg_req(reg_req), .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_ack(reg_ack), .reg_rdata(reg_rdata), .reg_bad_addr(reg_bad_addr),
    .reg_bad_value(reg_bad_value));
  mbsfh_checker #(.IDLE_CYCLES(IDLE)) mbsfh_checker_inst (
    .clock(clock), .rst_b(rst_b),
    .req_valid(mbsfh_link_if_inst.req_valid), .req_ready(mbsfh_link_if_inst.req_ready),
    .req_data(mbsfh_link_if_inst.req_data), .req_last(mbsfh_link_if_inst.req_last),
    .req_chan(mbsfh_link_if_inst.req_chan), .rsp_valid(mbsfh_link_if_inst.rsp_valid),
    .rsp_ready(mbsfh_link_if_inst.rsp_ready), .rsp_data(mbsfh_link_if_inst.rsp_data),
    .rsp_last(mbsfh_link_if_inst.rsp_last), .tcp_open(mbsfh_link_if_inst.tcp_open),
    .tcp_close(mbsfh_link_if_inst.tcp_close));

  // ********************
  // register port: acks every other cycle, word = address + 0x1000
  // ********************
  always @(posedge clock) begin
    reg_ack <= reg_req && !reg_ack;
    reg_rdata <= reg_addr + 16'h1000;
    reg_bad_addr <= bad_a;
    reg_bad_value <= bad_v;
    if (reg_ack && reg_req && reg_write) begin
      wd <= reg_wdata;
    end
  end

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one command; a zero expected length means no reply is expected
  task automatic run(input logic [1:0] ch, input logic [7:0] un, input logic [7:0] fc,
                     input logic [15:0] a, input logic [15:0] v, input logic [7:0] ef,
                     input logic [7:0] ec, input logic [15:0] ew, input logic [5:0] el);
    int k;
    logic rf;
    rf = !(fc inside {8'h03, 8'h04, 8'h06}) || (fc != 8'h06 && !(v inside {[1:13]}));
    @(posedge clock);
    cmd_chan <= ch;
    cmd_unit <= un;
    cmd_fc <= fc;
    cmd_addr <= a;
    cmd_value <= v;
    cmd_valid <= 1'b1;
    @(posedge clock);
    for (k = 0; k < 100 && cmd_ready !== 1'b1; k++) @(posedge clock);
    cmd_valid <= 1'b0;
    for (k = 0; k < 1000 && res_valid !== 1'b1; k++) @(posedge clock);
    chk("res_valid", 16'(res_valid), 16'h0001);
    chk("res_refused", 16'(res_refused), 16'(rf));
    chk("res_timeout", 16'(res_timeout), 16'(el == 6'h00 && !rf));
    if (el != 6'h00) begin
      chk("res_fc", 16'(res_fc), 16'(ef));
      chk("res_count", 16'(res_count), 16'(ec));
      chk("res_word", res_word, ew);
      chk("res_len", 16'(res_len), 16'(el));
      chk("res_exception", 16'(res_exception), 16'(ef[7]));
      if (ch != 2'h2) begin
        chk("res_crc_ok", 16'(res_crc_ok), 16'h0001);
      end
    end
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    end_sim();
  end

  initial begin
    int k;
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd_chan = 2'h0;
    cmd_unit = 8'h00;
    cmd_fc = 8'h00;
    cmd_tid = 16'ha55a;
    cmd_addr = 16'h0000;
    cmd_value = 16'h0000;
    rate_set = 4'h5;
    fmt_set = 3'h3;
    bad_a = 1'b0;
    bad_v = 1'b0;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    chk("uart_rate", 16'(uart_rate), 16'h0005);
    chk("uart_format", 16'(uart_format), 16'h0003);
    run(2'h0, 8'h11, 8'h04, 16'h0000, 16'h0001, 8'h04, 8'h02, 16'h1000, 6'h07);
    run(2'h0, 8'h11, 8'h03, 16'h0010, 16'h000d, 8'h03, 8'h1a, 16'h1010, 6'h1f);
    run(2'h1, 8'h11, 8'h04, 16'h0005, 16'h0002, 8'h04, 8'h04, 16'h1005, 6'h09);
    run(2'h0, 8'h11, 8'h06, 16'h000a, 16'h00c3, 8'h06, 8'h00, 16'h0a00, 6'h08);
    chk("reg_wdata", wd, 16'h00c3);
    run(2'h0, 8'h11, 8'h04, 16'h0000, 16'h0000, 8'h00, 8'h00, 16'h0000, 6'h00);
    run(2'h0, 8'h11, 8'h03, 16'h0000, 16'h000e, 8'h00, 8'h00, 16'h0000, 6'h00);
    run(2'h0, 8'h11, 8'h05, 16'h0000, 16'h0001, 8'h00, 8'h00, 16'h0000, 6'h00);
    bad_a <= 1'b1;
    run(2'h0, 8'h11, 8'h04, 16'h0100, 16'h0001, 8'h84, 8'h02, 16'h0001, 6'h07);
    bad_a <= 1'b0;
    bad_v <= 1'b1;
    run(2'h0, 8'h11, 8'h06, 16'h0003, 16'hffff, 8'h86, 8'h02, 16'h0002, 6'h07);
    bad_v <= 1'b0;
    run(2'h0, 8'h22, 8'h04, 16'h0000, 16'h0001, 8'h00, 8'h00, 16'h0000, 6'h00);
    rate_set <= 4'ha;
    fmt_set <= 3'h6;
    repeat (2) @(posedge clock);
    chk("uart_rate", 16'(uart_rate), 16'h000a);
    chk("uart_format", 16'(uart_format), 16'h0006);
    run(2'h2, 8'h11, 8'h04, 16'h0000, 16'h0002, 8'h04, 8'h04, 16'h1000, 6'h0d);
    run(2'h2, 8'h11, 8'h06, 16'h0007, 16'h1234, 8'h06, 8'h00, 16'h0712, 6'h0c);
    bad_a <= 1'b1;
    run(2'h2, 8'h11, 8'h03, 16'h0040, 16'h0001, 8'h83, 8'h02, 16'h0001, 6'h0b);
    bad_a <= 1'b0;
    // close lands a little before IDLE after the result
    for (k = 0; k < 400 && mbsfh_link_if_inst.tcp_close !== 1'b1; k++) @(posedge clock);
    chk("close_gap", 16'(k >= IDLE - 30 && k <= IDLE), 16'h0001);
    repeat (2) @(posedge clock);
    chk("tcp_open", 16'(mbsfh_link_if_inst.tcp_open), 16'h0000);
    end_sim();
  end
endmodule

// *** verilog/mbsfh_device.sv ***
// device end: parses rtu and tcp requests, reads or writes registers, replies
// assumes config settings and the register port are on the core clock
//
// How it works
// - close tcp link after 60 s idle
// - only functions 3, 4 read, 6 write
// - tcp request: ids, length 6, unit, fields
// - read count must be 1 to 13
// - tcp read reply: ids, length, count, data
// - tcp write reply echoes the request
// - exception function is the request function with the top bit set, count, code
// - codes: 1 address, 2 value, 3 function
// - rtu read request is eight bytes
// - rtu write request is eight bytes
// - rtu read reply: address, function, count, data, crc
// - rtu write reply echoes the request
// - rate, format, station from separate settings
// - rtu framing on usb and rs485
// - each register is two bytes, high first
`include "mbsfh_map.svh"

module mbsfh_device
  import mbsfh_pkg::*;
#(
  parameter longint unsigned IDLE_CYCLES = 64'(`MB_TCP_IDLE_S) * 64'(`MB_CLK_HZ)
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // link to the remote master
  mbsfh_link_if.device     link,
  // configuration settings
  input  wire logic [3:0]  serial_line_rate_setting,
  input  wire logic [2:0]  serial_char_format_setting,
  input  wire logic [7:0]  station_address,
  output logic      [3:0]  uart_rate,
  output logic      [2:0]  uart_format,
  // register access
  output logic             reg_req,
  output logic             reg_write,
  output logic      [15:0] reg_addr,
  output logic      [15:0] reg_wdata,
  input  wire logic        reg_ack,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_bad_addr,
  input  wire logic        reg_bad_value
);

  if (IDLE_CYCLES < 64'h1 || IDLE_CYCLES > 64'h0000_0000_ffff_ffff) begin : g_chk
    $error("IDLE_CYCLES must fit 1 to 2**32-1");
  end

  localparam logic [31:0] IDLE_LAST = 32'(IDLE_CYCLES - 64'h1);

  mbsfh_dev_t  r;
  mbsfh_dev_t  nx;
  logic [5:0]  hdr;
  logic [3:0]  hb;
  logic [5:0]  bl;
  logic [5:0]  tlen;
  logic [7:0]  fc;
  logic [15:0] rq_addr;
  logic [15:0] rq_val;
  logic        push;
  logic        pop;
  logic        last;
  logic        ok;
  logic        tcp_used;
  logic [7:0]  tx_byte;

  // ***********************************
  // reply byte at the current position
  // ***********************************
  function automatic logic [7:0] out_byte(input mbsfh_dev_t s, input logic [5:0] h,
                                          input logic [5:0] b_len);
    logic [5:0]  k;
    logic [5:0]  kk;
    logic [3:0]  base;
    logic [15:0] w;
    logic [7:0]  b;
    k    = s.tx_pos - h;
    kk   = k - 6'h03;
    base = s.rx_tcp ? 4'h6 : 4'h0;
    w    = s.words[kk[4:1]];
    // tcp header copies ids, length counts from unit
    if (s.rx_tcp && s.tx_pos < 6'h04) b = s.frame[s.tx_pos[3:0]];
    else if (s.rx_tcp && s.tx_pos == 6'h04) b = 8'h00;
    else if (s.rx_tcp && s.tx_pos == 6'h05) b = {2'b00, b_len};
    // crc trails the body, low byte first
    else if (k >= b_len) b = (k == b_len) ? s.tx_crc[7:0] : s.tx_crc[15:8];
    else if (k == 6'h00) b = s.frame[base];
    // exception sets the top bit of the function
    else if (k == 6'h01) b = s.exc ? (s.frame[base + 4'h1] | `MB_EXC_FLAG)
                                   : s.frame[base + 4'h1];
    else if (s.exc) b = (k == 6'h02) ? `MB_EXC_BCNT : (k == 6'h03) ? 8'h00 : s.code;
    // write echo copies the request body
    else if (s.wr) b = s.frame[base + k[3:0]];
    else if (k == 6'h02) b = {3'b000, s.n, 1'b0};
    // register data high byte then low byte
    else b = kk[0] ? w[7:0] : w[15:8];
    return b;
  endfunction

  // ***********************************
  // next state
  // ***********************************
  always_comb begin
    nx       = r;
    nx.close = 1'b0;
    tcp_used = 1'b0;
    ok       = 1'b0;
    hdr      = r.rx_tcp ? 6'h06 : 6'h00;
    hb       = r.rx_tcp ? 4'h6 : 4'h0;
    fc       = r.frame[hb + 4'h1];
    rq_addr  = {r.frame[hb + 4'h2], r.frame[hb + 4'h3]};
    rq_val   = {r.frame[hb + 4'h4], r.frame[hb + 4'h5]};
    bl       = r.exc ? 6'h05 : r.wr ? 6'h06 : 6'h03 + {1'b0, r.n, 1'b0};
    tlen     = hdr + bl + (r.rx_tcp ? 6'h00 : 6'h02);
    last     = r.tx_pos == tlen - 6'h01;
    tx_byte  = out_byte(r, hdr, bl);
    push     = (r.st == ST_TX) && (r.f_cnt != 2'h2);
    pop      = link.rsp_valid && link.rsp_ready;
    // each setting is its own input
    nx.rate  = serial_line_rate_setting;
    nx.fmt   = serial_char_format_setting;
    case (r.st)
      ST_RX: begin
        if (link.req_valid) begin
          if (r.rx_cnt == 4'h0) begin
            // rs485 and usb both take rtu framing
            nx.rx_tcp = link.req_chan == `MB_CH_TCP;
            nx.rx_bad = link.req_chan == `MB_CH_NONE;
          end
          if (r.rx_cnt < 4'hc) nx.frame[r.rx_cnt] = link.req_data;
          if (r.rx_cnt != 4'hf) nx.rx_cnt = r.rx_cnt + 4'h1;
          nx.crc = mbsfh_crc(r.crc, link.req_data);
          if (link.req_last) nx.st = ST_EXEC;
        end
      end
      ST_EXEC: begin
        nx.st     = ST_RX;
        nx.rx_cnt = 4'h0;
        nx.crc    = `MB_CRC_INIT;
        nx.tx_crc = `MB_CRC_INIT;
        nx.tx_pos = 6'h00;
        nx.exc    = 1'b0;
        nx.wr     = 1'b0;
        nx.widx   = 4'h0;
        nx.addr   = rq_addr;
        nx.n      = rq_val[3:0];
        // tcp: twelve bytes, length field 6
        if (r.rx_tcp) ok = (r.rx_cnt == 4'hc) && (r.frame[4] == 8'h00)
                           && (r.frame[5] == `MB_TCP_LEN);
        // eight bytes, crc residue zero, our station
        else ok = (r.rx_cnt == 4'h8) && (r.crc == 16'h0000)
                  && (r.frame[0] == station_address);
        if (ok && !r.rx_bad) begin
          tcp_used = r.rx_tcp;
          // both read codes take the same path
          if (fc == `MB_FC_RD_HOLD || fc == `MB_FC_RD_INP) begin
            // count outside 1 to 13 is refused
            if (rq_val == 16'h0000 || rq_val > 16'(`MB_MAX_REGS)) begin
              nx.exc  = 1'b1;
              nx.code = `MB_ERR_ADDR;
              nx.st   = ST_TX;
            end else begin
              nx.st = ST_REG;
            end
          end else if (fc == `MB_FC_WR_ONE) begin
            nx.wr = 1'b1;
            nx.st = ST_REG;
          end else begin
            nx.exc  = 1'b1;
            nx.code = `MB_ERR_FUNC;
            nx.st   = ST_TX;
          end
        end
      end
      ST_REG: begin
        if (reg_ack) begin
          // missing address wins over a bad value
          if (reg_bad_addr) begin
            nx.exc  = 1'b1;
            nx.code = `MB_ERR_ADDR;
            nx.st   = ST_TX;
          end else if (r.wr) begin
            if (reg_bad_value) begin
              nx.exc  = 1'b1;
              nx.code = `MB_ERR_VALUE;
            end
            nx.st = ST_TX;
          end else begin
            nx.words[r.widx] = reg_rdata;
            nx.widx          = r.widx + 4'h1;
            nx.addr          = r.addr + 16'h0001;
            if (r.widx == r.n - 4'h1) nx.st = ST_TX;
          end
        end
      end
      ST_TX: begin
        if (push) begin
          nx.fifo[r.f_wr] = {last, tx_byte};
          nx.f_wr         = ~r.f_wr;
          nx.tx_pos       = r.tx_pos + 6'h01;
          // crc bytes themselves stay out of the sum
          if (r.tx_pos < bl) nx.tx_crc = mbsfh_crc(r.tx_crc, tx_byte);
          if (last) nx.st = ST_RX;
        end
      end
      default: nx.st = ST_RX;
    endcase
    // two-entry buffer: a stalled master just holds the sequencer in ST_TX
    if (pop) nx.f_rd = ~r.f_rd;
    if (push && !pop) nx.f_cnt = r.f_cnt + 2'h1;
    else if (!push && pop) nx.f_cnt = r.f_cnt - 2'h1;
    // idle timer restarts on each served tcp frame
    if (!link.tcp_open || tcp_used) begin
      nx.idle = 32'h0000_0000;
    end else if (r.idle == IDLE_LAST) begin
      nx.idle  = 32'h0000_0000;
      nx.close = 1'b1;
    end else begin
      nx.idle = r.idle + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      r        <= '0;
      r.crc    <= `MB_CRC_INIT;
      r.tx_crc <= `MB_CRC_INIT;
    end else begin
      r <= nx;
    end
  end

  // ***********************************
  // outputs
  // ***********************************
  assign link.req_ready = r.st == ST_RX;
  assign link.rsp_valid = r.f_cnt != 2'h0;
  assign link.rsp_data  = r.fifo[r.f_rd][7:0];
  assign link.rsp_last  = r.fifo[r.f_rd][8];
  assign link.tcp_close = r.close;
  assign reg_req        = r.st == ST_REG;
  assign reg_write      = r.wr;
  assign reg_addr       = r.addr;
  assign reg_wdata      = rq_val;
  assign uart_rate      = r.rate;
  assign uart_format    = r.fmt;

endmodule

// *** verilog/mbsfh_link_if.sv ***
// byte streams between the remote master and the device
// assumes both ends run on the same clock; no clocking block here
interface mbsfh_link_if;
  // request stream, master to device
  logic       req_valid;
  logic       req_ready;
  logic [7:0] req_data;
  logic       req_last;
  logic [1:0] req_chan;
  // response stream, device to master
  logic       rsp_valid;
  logic       rsp_ready;
  logic [7:0] rsp_data;
  logic       rsp_last;
  // tcp connection state
  logic       tcp_open;
  logic       tcp_close;

  modport device (
    input  req_valid, req_data, req_last, req_chan, rsp_ready, tcp_open,
    output req_ready, rsp_valid, rsp_data, rsp_last, tcp_close
  );
  modport master (
    output req_valid, req_data, req_last, req_chan, rsp_ready, tcp_open,
    input  req_ready, rsp_valid, rsp_data, rsp_last, tcp_close
  );
endinterface

// *** verilog/mbsfh_map.svh ***
// constants of the frame handler: framing, codes and timing
// assumes one core clock of 25 MHz shared by both ends
`ifndef MBSFH_MAP_SVH
`define MBSFH_MAP_SVH

// ***********************************
// timing
// ***********************************
`define MB_CLK_HZ      25000000
`define MB_TCP_IDLE_S  60
`define MB_RSP_WAIT_MS 100

// ***********************************
// framing
// ***********************************
`define MB_CRC_INIT    16'hffff
`define MB_CRC_POLY    16'ha001
`define MB_TCP_LEN     8'h06
`define MB_MAX_REGS    13
`define MB_CH_RS485    2'h0
`define MB_CH_USB      2'h1
`define MB_CH_TCP      2'h2
`define MB_CH_NONE     2'h3

// ***********************************
// function and error codes
// ***********************************
`define MB_FC_RD_HOLD  8'h03
`define MB_FC_RD_INP   8'h04
`define MB_FC_WR_ONE   8'h06
`define MB_EXC_FLAG    8'h80
`define MB_EXC_BCNT    8'h02
`define MB_ERR_ADDR    8'h01
`define MB_ERR_VALUE   8'h02
`define MB_ERR_FUNC    8'h03

`endif

// *** verilog/mbsfh_master.sv ***
// master end: frames one command, sends it, and collects the reply
// assumes the device end on the same clock over mbsfh_link_if
`include "mbsfh_map.svh"

module mbsfh_master
  import mbsfh_pkg::*;
#(
  parameter longint unsigned RSP_WAIT = 64'(`MB_RSP_WAIT_MS) * 64'(`MB_CLK_HZ) / 64'd1000
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // link to the device
  mbsfh_link_if.master     link,
  // command
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [1:0]  cmd_chan,
  input  wire logic [7:0]  cmd_unit,
  input  wire logic [7:0]  cmd_fc,
  input  wire logic [15:0] cmd_tid,
  input  wire logic [15:0] cmd_addr,
  input  wire logic [15:0] cmd_value,
  // result
  output logic             res_valid,
  output logic             res_refused,
  output logic             res_timeout,
  output logic             res_exception,
  output logic             res_crc_ok,
  output logic      [7:0]  res_fc,
  output logic      [7:0]  res_count,
  output logic      [15:0] res_word,
  output logic      [5:0]  res_len
);

  if (RSP_WAIT < 64'h1 || RSP_WAIT > 64'h0000_0000_ffff_ffff) begin : g_chk
    $error("RSP_WAIT must fit 1 to 2**32-1");
  end

  localparam logic [31:0] WAIT_LAST = 32'(RSP_WAIT - 64'h1);

  mbsfh_mst_t  r;
  mbsfh_mst_t  nx;
  logic [5:0]  tlen;
  logic [5:0]  k;
  logic [3:0]  hb;
  logic [15:0] crc_n;
  logic        legal;

  always_comb begin
    nx           = r;
    nx.res_valid = 1'b0;
    tlen         = r.tcp ? 6'h0c : 6'h08;
    k            = r.pos - (r.tcp ? 6'h06 : 6'h00);
    hb           = (cmd_chan == `MB_CH_TCP) ? 4'h6 : 4'h0;
    crc_n        = mbsfh_crc(r.crc, link.rsp_data);
    // only codes 3, 4, 6 and counts 1 to 13 go out
    legal = (cmd_chan != `MB_CH_NONE)
            && (cmd_fc == `MB_FC_WR_ONE
                || ((cmd_fc == `MB_FC_RD_HOLD || cmd_fc == `MB_FC_RD_INP)
                    && cmd_value != 16'h0000 && cmd_value <= 16'(`MB_MAX_REGS)));
    case (r.st)
      M_IDLE: begin
        if (cmd_valid) begin
          nx.refused = !legal;
          nx.timeout = 1'b0;
          if (!legal) begin
            nx.res_valid = 1'b1;
          end else begin
            // tcp ids, zero protocol, length 6
            nx.frame[0]        = cmd_tid[15:8];
            nx.frame[1]        = cmd_tid[7:0];
            nx.frame[2]        = 8'h00;
            nx.frame[3]        = 8'h00;
            nx.frame[4]        = 8'h00;
            nx.frame[5]        = `MB_TCP_LEN;
            // unit, function, then words high first
            nx.frame[hb]       = cmd_unit;
            nx.frame[hb+4'h1]  = cmd_fc;
            nx.frame[hb+4'h2]  = cmd_addr[15:8];
            nx.frame[hb+4'h3]  = cmd_addr[7:0];
            nx.frame[hb+4'h4]  = cmd_value[15:8];
            nx.frame[hb+4'h5]  = cmd_value[7:0];
            nx.chan            = cmd_chan;
            nx.tcp             = cmd_chan == `MB_CH_TCP;
            nx.pos             = 6'h00;
            nx.crc             = `MB_CRC_INIT;
            nx.st              = M_SEND;
          end
        end
      end
      M_SEND: begin
        if (link.req_ready) begin
          if (r.pos < 6'h06) nx.crc = mbsfh_crc(r.crc, link.req_data);
          nx.pos = r.pos + 6'h01;
          if (link.req_last) begin
            nx.st       = M_RECV;
            nx.pos      = 6'h00;
            nx.crc      = `MB_CRC_INIT;
            nx.wait_cnt = 32'h0000_0000;
            nx.exc      = 1'b0;
            nx.open     = r.open | r.tcp;
          end
        end
      end
      M_RECV: begin
        nx.wait_cnt = r.wait_cnt + 32'h0000_0001;
        if (link.rsp_valid) begin
          nx.crc      = crc_n;
          nx.pos      = r.pos + 6'h01;
          nx.wait_cnt = 32'h0000_0000;
          if (k == 6'h01) nx.fc = link.rsp_data;
          if (k == 6'h01) nx.exc = link.rsp_data[7];
          if (k == 6'h02) nx.cnt = link.rsp_data;
          if (k == 6'h03) nx.word[15:8] = link.rsp_data;
          if (k == 6'h04) nx.word[7:0] = link.rsp_data;
          if (link.rsp_last) begin
            nx.res_valid = 1'b1;
            nx.crc_ok    = r.tcp || crc_n == 16'h0000;
            nx.len       = r.pos + 6'h01;
            nx.st        = M_IDLE;
          end
        end else if (r.wait_cnt == WAIT_LAST) begin
          // a dropped request never answers, so give up
          nx.res_valid = 1'b1;
          nx.timeout   = 1'b1;
          nx.st        = M_IDLE;
        end
      end
      default: nx.st = M_IDLE;
    endcase
    if (link.tcp_close) nx.open = 1'b0;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      r     <= '0;
      r.crc <= `MB_CRC_INIT;
    end else begin
      r <= nx;
    end
  end

  assign cmd_ready      = r.st == M_IDLE;
  assign link.req_valid = r.st == M_SEND;
  // rtu checksum goes low byte first
  assign link.req_data  = (!r.tcp && r.pos == 6'h06) ? r.crc[7:0]
                        : (!r.tcp && r.pos == 6'h07) ? r.crc[15:8]
                        : r.frame[r.pos[3:0]];
  assign link.req_last  = r.pos == tlen - 6'h01;
  assign link.req_chan  = r.chan;
  assign link.rsp_ready = r.st == M_RECV;
  assign link.tcp_open  = r.open;
  assign res_valid      = r.res_valid;
  assign res_refused    = r.refused;
  assign res_timeout    = r.timeout;
  assign res_exception  = r.exc;
  assign res_crc_ok     = r.crc_ok;
  assign res_fc         = r.fc;
  assign res_count      = r.cnt;
  assign res_word       = r.word;
  assign res_len        = r.len;

endmodule

// *** verilog/mbsfh_pkg.sv ***
// types and the checksum step shared by both ends
// assumes mbsfh_map.svh is on the include path
`include "mbsfh_map.svh"

package mbsfh_pkg;

  typedef enum logic [1:0] {
    ST_RX   = 2'b00,
    ST_EXEC = 2'b01,
    ST_REG  = 2'b10,
    ST_TX   = 2'b11
  } mbsfh_dev_st_t;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_SEND = 2'b01,
    M_RECV = 2'b10
  } mbsfh_mst_st_t;

  typedef struct packed {
    mbsfh_dev_st_t                     st;
    logic [11:0][7:0]                  frame;
    logic [3:0]                        rx_cnt;
    logic                              rx_tcp;
    logic                              rx_bad;
    logic [15:0]                       crc;
    logic                              exc;
    logic [7:0]                        code;
    logic                              wr;
    logic [3:0]                        n;
    logic [3:0]                        widx;
    logic [15:0]                       addr;
    logic [`MB_MAX_REGS-1:0][15:0]     words;
    logic [5:0]                        tx_pos;
    logic [15:0]                       tx_crc;
    logic [1:0][8:0]                   fifo;
    logic                              f_wr;
    logic                              f_rd;
    logic [1:0]                        f_cnt;
    logic [31:0]                       idle;
    logic                              close;
    logic [3:0]                        rate;
    logic [2:0]                        fmt;
  } mbsfh_dev_t;

  typedef struct packed {
    mbsfh_mst_st_t    st;
    logic [11:0][7:0] frame;
    logic [1:0]       chan;
    logic             tcp;
    logic [5:0]       pos;
    logic [15:0]      crc;
    logic [31:0]      wait_cnt;
    logic             open;
    logic             res_valid;
    logic             refused;
    logic             timeout;
    logic             exc;
    logic             crc_ok;
    logic [7:0]       fc;
    logic [7:0]       cnt;
    logic [15:0]      word;
    logic [5:0]       len;
  } mbsfh_mst_t;

  // one byte of the reflected crc-16, low bit first
  function automatic logic [15:0] mbsfh_crc(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MB_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

endpackage
